// >>> hw/spc_protect_cmd.sv
`timescale 1ns/1ps
`include "spc_protect_map.svh"

module spc_protect_cmd (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_n_out,
  input wire logic single_wire_mode_in,
  input wire logic write_enable_latch_in,
  output logic [31:0] boot_setup_out,
  output logic [7:0] security_reg_out,
  output logic [7:0] lock_reg_out,
  output logic [`SPC_BLOCKS-1:0] persistent_protect_bit_out,
  output logic [`SPC_BLOCKS-1:0] dynamic_protect_bit_out,
  output logic block_protect_mode_out,
  output logic password_unlocked_out,
  output logic reset_memory_out,
  output logic write_enable_clear_out
);

  function automatic spc_pkg::spc_cmd_s spc_decode(input logic [7:0] op);
    spc_pkg::spc_cmd_s c;
    c = '0;
    case (op)
      `SPC_OP_BOOT_READ: c = '{1'b1, 1'b0, 1'b0, 3'h0, 1'b0, `SPC_BOOT_BYTES};
      `SPC_OP_BOOT_WRITE: c = '{1'b1, 1'b0, 1'b1, 3'h0, 1'b0, `SPC_BOOT_BYTES};
      `SPC_OP_SEC_READ: c = '{1'b1, 1'b0, 1'b0, 3'h0, 1'b0, `SPC_REG_BYTES};
      `SPC_OP_LOCK_WRITE: c = '{1'b1, 1'b0, 1'b1, 3'h0, 1'b0, `SPC_REG_BYTES};
      `SPC_OP_LOCK_READ: c = '{1'b1, 1'b0, 1'b0, 3'h0, 1'b0, `SPC_REG_BYTES};
      `SPC_OP_PP_PROGRAM: c = '{1'b1, 1'b0, 1'b1, `SPC_ADDR_BYTES, 1'b0, `SPC_NO_BYTES};
      `SPC_OP_PP_READ: c = '{1'b1, 1'b0, 1'b0, `SPC_ADDR_BYTES, 1'b0, `SPC_REG_BYTES};
      `SPC_OP_DP_WRITE: c = '{1'b1, 1'b0, 1'b1, `SPC_ADDR_BYTES, 1'b0, `SPC_REG_BYTES};
      `SPC_OP_DP_READ: c = '{1'b1, 1'b0, 1'b0, `SPC_ADDR_BYTES, 1'b0, `SPC_REG_BYTES};
      `SPC_OP_PW_READ: c = '{1'b1, 1'b1, 1'b0, `SPC_ADDR_BYTES, 1'b1, `SPC_PW_BYTES};
      `SPC_OP_PW_WRITE: c = '{1'b1, 1'b1, 1'b1, `SPC_ADDR_BYTES, 1'b0, `SPC_PW_BYTES};
      `SPC_OP_PW_UNLOCK: c = '{1'b1, 1'b1, 1'b1, `SPC_ADDR_BYTES, 1'b0, `SPC_PW_BYTES};
      `SPC_OP_BOOT_ERASE, `SPC_OP_SEC_LOCK, `SPC_OP_PP_ERASE_ALL, `SPC_OP_MODE_SELECT,
      `SPC_OP_CHIP_PROTECT, `SPC_OP_CHIP_UNPROTECT, `SPC_OP_RESET_ARM, `SPC_OP_RESET_MEM:
        c.valid = 1'b1;
      default: c = '0;
    endcase
    return c;
  endfunction : spc_decode

  // Link domain, clocked by the serial clock
  logic [2:0] bit_cnt;
  logic [6:0] rx_sh;
  logic mode_m;
  logic mode_q;
  spc_pkg::spc_state_e st;
  spc_pkg::spc_state_e next_st;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic next_post;
  logic next_done;
  logic [7:0] op;
  logic [31:0] addr;
  logic [63:0] dbuf;
  spc_pkg::spc_cmd_s cmd;
  spc_pkg::spc_post_s post_q;
  logic post_tgl;
  logic [7:0] tx_sh;
  logic [63:0] password;

  wire [7:0] rx_byte = {rx_sh, mosi_in};
  wire byte_end = bit_cnt == 3'h7;
  wire spc_pkg::spc_cmd_s dec = spc_decode(rx_byte);
  wire allowed = dec.valid && (!dec.single_only || mode_q);
  wire last_addr = cnt == {1'b0, cmd.addr_bytes} - 4'h1;
  wire last_data = cnt == cmd.data_len - 4'h1;
  wire [7:0] op_now = (st == spc_pkg::ST_OP) ? rx_byte : op;
  wire [31:0] addr_now = (st == spc_pkg::ST_ADDR) ? {addr[23:0], rx_byte} : addr;
  wire [63:0] data_now = (st == spc_pkg::ST_DATA) ? {dbuf[55:0], rx_byte} : dbuf;

  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      bit_cnt <= 3'h0;
      rx_sh <= 7'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_sh <= {rx_sh[5:0], mosi_in};
    end
  end

  // Mode is settled long before the eighth edge of the opcode
  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      {mode_q, mode_m} <= 2'h0;
    end else begin
      {mode_q, mode_m} <= {mode_m, single_wire_mode_in};
    end
  end

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_post = 1'b0;
    next_done = 1'b0;
    unique case (st)
      spc_pkg::ST_OP: begin
        next_cnt = 4'h0;
        // Every opcode is posted so the reset arm sees it
        next_post = 1'b1;
        if (!allowed) begin
          next_st = spc_pkg::ST_SKIP;
        end else if (dec.addr_bytes != 3'h0) begin
          next_st = spc_pkg::ST_ADDR;
        end else if (dec.data_len != 4'h0) begin
          next_st = spc_pkg::ST_DATA;
        end else begin
          next_st = spc_pkg::ST_SKIP;
          next_done = 1'b1;
        end
      end
      spc_pkg::ST_ADDR: begin
        next_cnt = cnt + 4'h1;
        if (last_addr) begin
          next_cnt = 4'h0;
          if (cmd.dummy) begin
            next_st = spc_pkg::ST_DUMMY;
          end else if (cmd.data_len != 4'h0) begin
            next_st = spc_pkg::ST_DATA;
          end else begin
            next_st = spc_pkg::ST_SKIP;
            next_post = 1'b1;
            next_done = 1'b1;
          end
        end
      end
      spc_pkg::ST_DUMMY: begin
        next_st = spc_pkg::ST_DATA;
        next_cnt = 4'h0;
      end
      spc_pkg::ST_DATA: begin
        next_cnt = cnt + 4'h1;
        if (last_data) begin
          next_cnt = 4'h0;
          if (cmd.write) begin
            // A write cut short by chip select is posted only with done clear
            next_st = spc_pkg::ST_SKIP;
            next_post = 1'b1;
            next_done = 1'b1;
          end
        end
      end
      spc_pkg::ST_SKIP: next_st = spc_pkg::ST_SKIP;
    endcase
  end

  always_ff @(posedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      st <= spc_pkg::ST_OP;
      cnt <= 4'h0;
      {op, addr, dbuf} <= 104'h0;
      cmd <= '0;
    end else if (byte_end) begin
      st <= next_st;
      cnt <= next_cnt;
      {op, addr, dbuf} <= {op_now, addr_now, data_now};
      if (st == spc_pkg::ST_OP) begin
        cmd <= dec;
      end
    end
  end

  // Post word is held until the next post, at least one byte time later
  always_ff @(posedge sclk_in or posedge reset_in) begin
    if (reset_in) begin
      post_tgl <= 1'b0;
      post_q <= '0;
    end else if (byte_end && next_post) begin
      post_q <= '{op_now, next_done, addr_now, data_now};
      post_tgl <= ~post_tgl;
    end
  end

  // Registers below change only on posts, so they are static while read here
  wire [`SPC_BLK_W-1:0] blk_rd = addr[`SPC_BLK_LSB +: `SPC_BLK_W];
  wire [7:0] boot_byte = boot_setup_out[{~cnt[1:0], 3'b000} +: 8];
  wire [7:0] pw_byte = password[{~cnt[2:0], 3'b000} +: 8];
  wire [7:0] rd_byte =
    (op == `SPC_OP_BOOT_READ) ? boot_byte :
    (op == `SPC_OP_SEC_READ) ? security_reg_out :
    (op == `SPC_OP_LOCK_READ) ? lock_reg_out :
    (op == `SPC_OP_PP_READ) ? {8{persistent_protect_bit_out[blk_rd]}} :
    (op == `SPC_OP_DP_READ) ? {8{dynamic_protect_bit_out[blk_rd]}} :
    (op == `SPC_OP_PW_READ) ? pw_byte : 8'h00;
  wire [7:0] tx_byte = (st == spc_pkg::ST_DATA && !cmd.write) ? rd_byte : 8'h00;

  always_ff @(negedge sclk_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      tx_sh <= 8'h00;
    end else if (bit_cnt == 3'h0) begin
      tx_sh <= tx_byte;
    end else begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  assign miso_out = tx_sh[7];
  assign miso_oe_n_out = cs_n_in;

  // Core domain, clocked by ref_clk_in
  logic pt_m;
  logic pt_q;
  logic pt_d;
  logic arm;
  logic lockdown;
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      {pt_d, pt_q, pt_m} <= 3'h0;
    end else begin
      {pt_d, pt_q, pt_m} <= {pt_q, pt_m, post_tgl};
    end
  end

  wire post_ev = pt_q ^ pt_d;
  wire [7:0] p_op = post_q.op;
  wire [63:0] p_data = post_q.data;
  wire [`SPC_BLK_W-1:0] blk_wr = post_q.addr[`SPC_BLK_LSB +: `SPC_BLK_W];
  wire wr_ok = post_ev && post_q.done && write_enable_latch_in;
  wire fire_rst = post_ev && p_op == `SPC_OP_RESET_MEM && arm;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      arm <= 1'b0;
      reset_memory_out <= 1'b0;
      write_enable_clear_out <= 1'b0;
    end else begin
      if (post_ev) begin
        arm <= p_op == `SPC_OP_RESET_ARM;
      end
      reset_memory_out <= fire_rst;
      write_enable_clear_out <= wr_ok && p_op != `SPC_OP_RESET_ARM && p_op != `SPC_OP_RESET_MEM;
    end
  end

  // Lockdown has a set path only; each post carries one command
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      boot_setup_out <= `SPC_BOOT_RST;
      lockdown <= 1'b0;
      lock_reg_out <= `SPC_LOCK_RST;
      block_protect_mode_out <= 1'b0;
      password <= `SPC_PW_RST;
      password_unlocked_out <= 1'b0;
    end else if (wr_ok) begin
      case (p_op)
        `SPC_OP_BOOT_WRITE: boot_setup_out <= p_data[31:0];
        `SPC_OP_BOOT_ERASE: boot_setup_out <= `SPC_BOOT_RST;
        `SPC_OP_SEC_LOCK: lockdown <= 1'b1;
        `SPC_OP_LOCK_WRITE: lock_reg_out <= p_data[7:0];
        `SPC_OP_MODE_SELECT: block_protect_mode_out <= 1'b1;
        `SPC_OP_PW_WRITE: password <= p_data;
        `SPC_OP_PW_UNLOCK: password_unlocked_out <= p_data == password;
        default: ;
      endcase
    end
  end
  assign security_reg_out = 8'({7'h00, lockdown} << `SPC_SEC_LOCK_BIT);

  genvar g;
  generate
    for (g = 0; g < `SPC_BLOCKS; g++) begin : g_blk
      wire hit = blk_wr == `SPC_BLK_W'(g);
      always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
          persistent_protect_bit_out[g] <= 1'b0;
          dynamic_protect_bit_out[g] <= 1'b0;
        end else if (wr_ok) begin
          case (p_op)
            `SPC_OP_PP_ERASE_ALL: persistent_protect_bit_out[g] <= 1'b0;
            `SPC_OP_PP_PROGRAM: persistent_protect_bit_out[g] <= persistent_protect_bit_out[g] | hit;
            `SPC_OP_CHIP_PROTECT: dynamic_protect_bit_out[g] <= 1'b1;
            `SPC_OP_CHIP_UNPROTECT: dynamic_protect_bit_out[g] <= 1'b0;
            `SPC_OP_DP_WRITE: dynamic_protect_bit_out[g] <= hit ? |p_data[7:0] : dynamic_protect_bit_out[g];
            default: ;
          endcase
        end
      end
    end
  endgenerate

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);

  lockdown_sticky_a: assert property (lockdown |=> lockdown) else $error("lockdown bit cleared");
  reset_armed_a: assert property (reset_memory_out |-> $past(arm, 1) && $past(post_ev, 1))
    else $error("reset without arm");
  arm_cancel_a: assert property (post_ev && p_op != `SPC_OP_RESET_ARM |=> !arm) else $error("arm kept");
  reset_pulse_a: assert property (fire_rst |=> reset_memory_out ##1 !reset_memory_out)
    else $error("reset pulse wrong");
  chip_protect_a: assert property (wr_ok && p_op == `SPC_OP_CHIP_PROTECT |=> &dynamic_protect_bit_out)
    else $error("chip protect incomplete");
  chip_unprot_a: assert property (wr_ok && p_op == `SPC_OP_CHIP_UNPROTECT |=> dynamic_protect_bit_out == '0)
    else $error("chip unprotect incomplete");
  mode_select_a: assert property (wr_ok && p_op == `SPC_OP_MODE_SELECT |=> block_protect_mode_out)
    else $error("block mode not entered");
  lock_write_a: assert property (wr_ok && p_op == `SPC_OP_LOCK_WRITE |=> lock_reg_out == $past(p_data[7:0]))
    else $error("lock register not written");
  no_wel_a: assert property (post_ev && !write_enable_latch_in |=> $stable(boot_setup_out) && $stable(password))
    else $error("write without enable latch");
  pw_unlock_a: assert property (wr_ok && p_op == `SPC_OP_PW_UNLOCK && p_data == password
    |=> password_unlocked_out)
    else $error("unlock failed on match");

  reset_seen_c: cover property (reset_memory_out);
  unlock_seen_c: cover property (password_unlocked_out);
  lockdown_seen_c: cover property (!lockdown ##1 lockdown);
  boot_write_c: cover property (wr_ok && p_op == `SPC_OP_BOOT_WRITE);

endmodule : spc_protect_cmd

// >>> hw/spc_protect_map.svh
`ifndef SPC_PROTECT_MAP_SVH
`define SPC_PROTECT_MAP_SVH

// Opcodes
`define SPC_OP_BOOT_READ 8'h16
`define SPC_OP_BOOT_WRITE 8'h17
`define SPC_OP_BOOT_ERASE 8'h18
`define SPC_OP_SEC_READ 8'h2b
`define SPC_OP_SEC_LOCK 8'h2f
`define SPC_OP_LOCK_WRITE 8'h2c
`define SPC_OP_LOCK_READ 8'h2d
`define SPC_OP_PP_PROGRAM 8'he3
`define SPC_OP_PP_ERASE_ALL 8'he4
`define SPC_OP_PP_READ 8'he2
`define SPC_OP_DP_WRITE 8'he1
`define SPC_OP_DP_READ 8'he0
`define SPC_OP_MODE_SELECT 8'h68
`define SPC_OP_CHIP_PROTECT 8'h7e
`define SPC_OP_CHIP_UNPROTECT 8'h98
`define SPC_OP_PW_READ 8'h27
`define SPC_OP_PW_WRITE 8'h28
`define SPC_OP_PW_UNLOCK 8'h29
`define SPC_OP_RESET_ARM 8'h66
`define SPC_OP_RESET_MEM 8'h99

// Field lengths in bytes
`define SPC_ADDR_BYTES 3'h4
`define SPC_BOOT_BYTES 4'h4
`define SPC_PW_BYTES 4'h8
`define SPC_REG_BYTES 4'h1
`define SPC_NO_BYTES 4'h0

// Field positions and sizes
`define SPC_SEC_LOCK_BIT 1
`define SPC_BLOCKS 16
`define SPC_BLK_W 4
`define SPC_BLK_LSB 24

// Reset values
`define SPC_BOOT_RST 32'hffff_ffff
`define SPC_PW_RST 64'hffff_ffff_ffff_ffff
`define SPC_LOCK_RST 8'h00

`endif

// >>> hw/spc_pkg.sv
package spc_pkg;

  typedef enum logic [4:0] {
    ST_OP = 5'h01,
    ST_ADDR = 5'h02,
    ST_DUMMY = 5'h04,
    ST_DATA = 5'h08,
    ST_SKIP = 5'h10
  } spc_state_e;

  typedef struct packed {
    logic valid;
    logic single_only;
    logic write;
    logic [2:0] addr_bytes;
    logic dummy;
    logic [3:0] data_len;
  } spc_cmd_s;

  typedef struct packed {
    logic [7:0] op;
    logic done;
    logic [31:0] addr;
    logic [63:0] data;
  } spc_post_s;

endpackage : spc_pkg

// >>> verif/spc_host_model.sv
`timescale 1ns/1ps
module spc_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  localparam time HALF = 32ns;

  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b1;
  end

  // One frame; sclk stands low outside it and MOSI toggles once released
  task automatic xfer(input logic [7:0] tx[$], input int nrd, output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    cs_n_out = 1'b0;
    #HALF;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        mosi_out = tx[i][k];
        #HALF sclk_out = 1'b1;
        #HALF sclk_out = 1'b0;
      end
    end
    for (int j = 0; j < nrd; j++) begin
      for (int k = 7; k >= 0; k--) begin
        mosi_out = ~mosi_out;
        #HALF sclk_out = 1'b1;
        b[k] = miso_in;
        #HALF sclk_out = 1'b0;
      end
      rx.push_back(b);
    end
    #HALF cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    // Gap covers core execution latency and the minimum deselect time
    #200;
  endtask : xfer
endmodule : spc_host_model

// >>> verif/spc_protect_cmd_tb_top.sv
`timescale 1ns/1ps
module spc_protect_cmd_tb_top;
  logic ref_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic single_wire_mode_in = 1'b1;
  logic write_enable_latch_in = 1'b1;
  logic sclk, cs_n, mosi, miso, miso_oe_n, mode, unlocked, rst_mem, wec;
  logic [31:0] boot;
  logic [7:0] sec, lock;
  logic [15:0] pp, dp;
  logic [7:0] rx[$];
  int n_mismatch = 0;
  int num_checks = 0;
  int n_rst = 0;
  int n_wec = 0;
  int cycles = 0;

  initial forever #10 ref_clk_in = ~ref_clk_in;

  spc_protect_cmd u_spc_protect_cmd (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .sclk_in(sclk),
    .cs_n_in(cs_n),
    .mosi_in(mosi),
    .miso_out(miso),
    .miso_oe_n_out(miso_oe_n),
    .single_wire_mode_in(single_wire_mode_in),
    .write_enable_latch_in(write_enable_latch_in),
    .boot_setup_out(boot),
    .security_reg_out(sec),
    .lock_reg_out(lock),
    .persistent_protect_bit_out(pp),
    .dynamic_protect_bit_out(dp),
    .block_protect_mode_out(mode),
    .password_unlocked_out(unlocked),
    .reset_memory_out(rst_mem),
    .write_enable_clear_out(wec)
  );

  spc_host_model u_spc_host_model (
    .sclk_out(sclk),
    .cs_n_out(cs_n),
    .mosi_out(mosi),
    .miso_in(miso)
  );

  always @(posedge ref_clk_in) begin
    cycles++;
    if (rst_mem === 1'b1) n_rst++;
    if (wec === 1'b1) n_wec++;
    if (cycles == 40000) begin
      n_mismatch++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic run(input logic [7:0] tx[$], input int nrd);
    u_spc_host_model.xfer(tx, nrd, rx);
  endtask : run

  task automatic pw_cmd(input logic [7:0] op, input logic [63:0] v, input int nrd);
    logic [7:0] q[$];
    q = '{op, 8'h00, 8'h00, 8'h00, 8'h00};
    if (nrd > 0) q.push_back(8'h00);
    else for (int i = 7; i >= 0; i--) q.push_back(v[i*8+:8]);
    run(q, nrd);
  endtask : pw_cmd

  task automatic t_lock;
    int w;
    w = n_wec;
    run('{8'h2c, 8'haa}, 0);
    chk(lock, 8'haa, "lock write");
    chk(n_wec - w, 1, "latch clear pulse");
    run('{8'h2d}, 2);
    chk({rx[0], rx[1]}, 16'haaaa, "lock read");
    chk(miso_oe_n, 1'b1, "miso released");
    $display("test lock done");
  endtask : t_lock

  task automatic t_wel;
    @(negedge ref_clk_in) write_enable_latch_in = 1'b0;
    run('{8'h2c, 8'h55}, 0);
    chk(lock, 8'haa, "write refused");
    run('{8'h2f}, 0);
    chk(sec, 8'h00, "lockdown refused");
    @(negedge ref_clk_in) write_enable_latch_in = 1'b1;
    $display("test latch done");
  endtask : t_wel

  task automatic t_reset;
    int n;
    n = n_rst;
    run('{8'h99}, 0);
    chk(n_rst - n, 0, "unarmed reset");
    run('{8'h66}, 0);
    run('{8'h2d}, 1);
    run('{8'h99}, 0);
    chk(n_rst - n, 0, "cancelled reset");
    run('{8'h66}, 0);
    run('{8'h99}, 0);
    chk(n_rst - n, 1, "armed reset");
    run('{8'h99}, 0);
    chk(n_rst - n, 1, "arm consumed");
    $display("test reset done");
  endtask : t_reset

  task automatic t_boot;
    run('{8'h17, 8'h12, 8'h34, 8'h56, 8'h78}, 0);
    chk(boot, 32'h1234_5678, "boot write");
    run('{8'h16}, 5);
    chk({rx[0], rx[1], rx[2], rx[3], rx[4]}, 40'h12_3456_7812, "boot read");
    run('{8'h18}, 0);
    chk(boot, 32'hffff_ffff, "boot erase");
    $display("test boot done");
  endtask : t_boot

  task automatic t_sec;
    run('{8'h2b}, 1);
    chk(rx[0], 8'h00, "security read");
    run('{8'h2f}, 0);
    chk(sec, 8'h02, "lockdown set");
    run('{8'h2b}, 1);
    chk(rx[0], 8'h02, "security read locked");
    $display("test security done");
  endtask : t_sec

  task automatic t_prot;
    run('{8'he1, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01}, 0);
    chk(dp, 16'h0020, "dynamic set");
    run('{8'he0, 8'h05, 8'h00, 8'h00, 8'h00}, 1);
    chk(rx[0], 8'hff, "dynamic read");
    run('{8'he1, 8'h05, 8'h00, 8'h00, 8'h00, 8'h00}, 0);
    chk(dp, 16'h0000, "dynamic clear");
    run('{8'he3, 8'h03, 8'h00, 8'h00, 8'h00}, 0);
    chk(pp, 16'h0008, "persistent program");
    run('{8'he2, 8'h03, 8'h00, 8'h00, 8'h00}, 1);
    chk(rx[0], 8'hff, "persistent read set");
    run('{8'he2, 8'h04, 8'h00, 8'h00, 8'h00}, 1);
    chk(rx[0], 8'h00, "persistent read clear");
    run('{8'he4}, 0);
    chk(pp, 16'h0000, "persistent erase");
    run('{8'h68}, 0);
    chk(mode, 1'b1, "block mode");
    run('{8'h7e}, 0);
    chk(dp, 16'hffff, "chip protect");
    run('{8'h98}, 0);
    chk(dp, 16'h0000, "chip unprotect");
    $display("test protect done");
  endtask : t_prot

  task automatic t_pw;
    logic [63:0] pw, got;
    pw = 64'h0123_4567_89ab_cdef;
    pw_cmd(8'h28, pw, 0);
    pw_cmd(8'h27, 64'h0, 8);
    foreach (rx[i]) got[(7-i)*8+:8] = rx[i];
    chk(got, pw, "password read");
    pw_cmd(8'h29, pw, 0);
    chk(unlocked, 1'b1, "unlock");
    @(negedge ref_clk_in) single_wire_mode_in = 1'b0;
    pw_cmd(8'h29, pw ^ 64'h1, 0);
    chk(unlocked, 1'b1, "unlock refused");
    pw_cmd(8'h27, 64'h0, 1);
    chk(rx[0], 8'h00, "read refused");
    @(negedge ref_clk_in) single_wire_mode_in = 1'b1;
    pw_cmd(8'h29, pw ^ 64'h1, 0);
    chk(unlocked, 1'b0, "wrong unlock");
    $display("test password done");
  endtask : t_pw

  initial begin
    repeat (6) @(negedge ref_clk_in);
    reset_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    chk({boot, lock, sec}, 48'hffff_ffff_0000, "reset values");
    chk({pp, dp, mode, unlocked}, 34'h0, "reset protect");
    t_lock();
    t_wel();
    t_reset();
    t_boot();
    t_sec();
    t_prot();
    t_pw();
    conclude();
  end
endmodule : spc_protect_cmd_tb_top
